// *** design/gils_pkg.sv ***
package gils_pkg;

    // ==========================================================
    // Widths
    localparam int GPIO_N = 12;
    localparam int LED_N = 8;
    localparam int FUNC_W = 2;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // ==========================================================
    // Register byte addresses
    localparam logic [ADDR_W-1:0] LED_PIN_CONFIG_ADDR = 12'h01bc;
    localparam logic [ADDR_W-1:0] GPIO_IRQ_STATUS_ENABLE_ADDR = 12'h01e8;

    // ==========================================================
    // Field positions
    localparam int IRQ_STATUS_LSB = 0;
    localparam int IRQ_ENABLE_LSB = 16;
    localparam int PIN_SELECT_LSB = 0;
    localparam int FUNCTION_LSB = 8;

    // ==========================================================
    // Reset values
    localparam logic [GPIO_N-1:0] IRQ_STATUS_RESET = 12'h0000;
    localparam logic [GPIO_N-1:0] IRQ_ENABLE_RESET = 12'h0000;
    localparam logic [LED_N-1:0] PIN_SELECT_RESET = 8'h00;
    localparam logic [FUNC_W-1:0] FUNCTION_RESET = 2'h0;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int IRQ_MIN_LEVEL_PS = 40000;
    // Shortest time a level must be held: rounds down, at least one cycle
    localparam int IRQ_HOLD_CYCLES_RAW = IRQ_MIN_LEVEL_PS / CLK_PERIOD_PS;
    localparam int IRQ_HOLD_CYCLES =
        (IRQ_HOLD_CYCLES_RAW < 1) ? 1 : IRQ_HOLD_CYCLES_RAW;
    // Cycles after reset release before straps are sampled
    localparam int STRAP_SETTLE_CYCLES = 3;

endpackage

// *** design/gils_level_filter.sv ***
`timescale 1ns/1ps
`default_nettype none

module gils_level_filter #(
    parameter int HOLD_CYCLES = 8
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic pin_in,
    input wire logic active_high_in,
    output logic active_out
);

    localparam int CNT_W = $clog2(HOLD_CYCLES + 1);
    // Synchroniser plus qualification must fit inside the hold time
    localparam int QUAL = (HOLD_CYCLES > 3) ? HOLD_CYCLES - 3 : 1;
    localparam logic [CNT_W-1:0] QUAL_CNT = CNT_W'(QUAL);

    logic sync1_r;
    logic sync2_r;
    logic [CNT_W-1:0] cnt_r;
    logic active_r;
    logic lvl;

    // ==========================================================
    // Two-stage synchroniser
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    assign lvl = (sync2_r == active_high_in);

    // ==========================================================
    // Short pulses are rejected, long ones always pass
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r <= '0;
            active_r <= 1'b0;
        end else if (!lvl) begin
            cnt_r <= '0;
            active_r <= 1'b0;
        end else if (cnt_r != QUAL_CNT) begin
            cnt_r <= cnt_r + CNT_W'(1);
            active_r <= (cnt_r + CNT_W'(1)) == QUAL_CNT;
        end else begin
            active_r <= 1'b1;
        end
    end

    assign active_out = active_r;

endmodule // gils_level_filter

`default_nettype wire

// *** design/gils_indicator_cfg.sv ***
`timescale 1ns/1ps
`default_nettype none

module gils_indicator_cfg
    import gils_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [gils_pkg::LED_N-1:0] select_strap_in,
    input wire logic [gils_pkg::FUNC_W-1:0] function_strap_in,
    input wire logic rom_load_in,
    input wire logic [gils_pkg::LED_N-1:0] rom_select_in,
    input wire logic [gils_pkg::FUNC_W-1:0] rom_function_in,
    input wire logic host_wr_in,
    input wire logic [gils_pkg::LED_N-1:0] host_select_in,
    input wire logic [gils_pkg::FUNC_W-1:0] host_function_in,
    output logic [gils_pkg::LED_N-1:0] select_out,
    output logic [gils_pkg::FUNC_W-1:0] function_out
);

    localparam int SW = LED_N + FUNC_W;

    logic [SW-1:0] strap_s1_r;
    logic [SW-1:0] strap_s2_r;
    logic [1:0] settle_r;
    logic captured_r;
    logic [LED_N-1:0] select_r;
    logic [FUNC_W-1:0] function_r;

    // ==========================================================
    // Strap pins are asynchronous: synchronise before capture
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            strap_s1_r <= '0;
            strap_s2_r <= '0;
        end else begin
            strap_s1_r <= {function_strap_in, select_strap_in};
            strap_s2_r <= strap_s1_r;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            settle_r <= 2'h0;
            captured_r <= 1'b0;
        end else if (!captured_r) begin
            settle_r <= settle_r + 2'h1;
            captured_r <= (settle_r == 2'(STRAP_SETTLE_CYCLES - 1));
        end
    end

    // ==========================================================
    // Strap capture once after release, then loader, then host
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            select_r <= PIN_SELECT_RESET;
            function_r <= FUNCTION_RESET;
        end else if (!captured_r) begin
            if (settle_r == 2'(STRAP_SETTLE_CYCLES - 1)) begin
                select_r <= strap_s2_r[LED_N-1:0];
                function_r <= strap_s2_r[SW-1:LED_N];
            end
        end else if (rom_load_in) begin
            select_r <= rom_select_in;
            function_r <= rom_function_in;
        end else if (host_wr_in) begin
            select_r <= host_select_in;
            function_r <= host_function_in;
        end
    end

    assign select_out = select_r;
    assign function_out = function_r;

endmodule // gils_indicator_cfg

`default_nettype wire

// *** design/gils_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module gils_top
    import gils_pkg::*;
(
    input wire logic REF_CLK_IN,
    input wire logic RESETN_IN,
    input wire logic [gils_pkg::ADDR_W-1:0] ADDR_IN,
    input wire logic [gils_pkg::DATA_W-1:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [gils_pkg::DATA_W-1:0] RDATA_OUT,
    input wire logic [gils_pkg::GPIO_N-1:0] GPIO_PIN_IN,
    input wire logic [gils_pkg::GPIO_N-1:0] GPIO_IRQ_ACTIVE_HIGH_IN,
    input wire logic [gils_pkg::GPIO_N-1:0] GPIO_DATA_IN,
    input wire logic [gils_pkg::GPIO_N-1:0] GPIO_DIR_IN,
    input wire logic [4*gils_pkg::LED_N-1:0] INDICATOR_SOURCE_IN,
    output logic [gils_pkg::GPIO_N-1:0] GPIO_PIN_OUT,
    output logic [gils_pkg::GPIO_N-1:0] GPIO_PIN_OE_OUT,
    input wire logic CHIP_IRQ_GPIO_ENABLE_IN,
    output logic CHIP_IRQ_STATUS_GPIO_OUT,
    output logic IRQ_OUT,
    input wire logic [gils_pkg::LED_N-1:0] INDICATOR_SELECT_STRAP_IN,
    input wire logic [gils_pkg::FUNC_W-1:0] INDICATOR_FUNCTION_STRAP_IN,
    input wire logic ROM_LOAD_VALID_IN,
    input wire logic [gils_pkg::LED_N-1:0] ROM_LOAD_SELECT_IN,
    input wire logic [gils_pkg::FUNC_W-1:0] ROM_LOAD_FUNCTION_IN,
    output logic [gils_pkg::LED_N-1:0] INDICATOR_PIN_SELECT_OUT,
    output logic [gils_pkg::FUNC_W-1:0] INDICATOR_FUNCTION_SELECT_OUT,
    output logic [2*gils_pkg::LED_N-1:0] INDICATOR_PIN_FUNCTION_OUT
);

    import gils_pkg::*;

    // ==========================================================
    // Declarations
    logic wr_irq;
    logic wr_led;
    logic rd_irq;
    logic rd_led;
    logic [GPIO_N-1:0] pin_active;
    logic [GPIO_N-1:0] irq_status_r;
    logic [GPIO_N-1:0] irq_status_nxt;
    logic [GPIO_N-1:0] irq_enable_r;
    logic [GPIO_N-1:0] w1c_mask;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic chip_status_r;
    logic irq_r;
    logic [LED_N-1:0] pin_select;
    logic [FUNC_W-1:0] pin_function;
    logic [2*LED_N-1:0] pin_func_r;
    logic [2*LED_N-1:0] pin_func_nxt;
    logic [GPIO_N-1:0] pin_out_r;
    logic [GPIO_N-1:0] pin_out_nxt;
    logic [GPIO_N-1:0] pin_oe_r;
    logic [GPIO_N-1:0] pin_oe_nxt;

    // ==========================================================
    // Address decode
    assign wr_irq = WR_IN && (ADDR_IN == GPIO_IRQ_STATUS_ENABLE_ADDR);
    assign wr_led = WR_IN && (ADDR_IN == LED_PIN_CONFIG_ADDR);
    assign rd_irq = RD_IN && (ADDR_IN == GPIO_IRQ_STATUS_ENABLE_ADDR);
    assign rd_led = RD_IN && (ADDR_IN == LED_PIN_CONFIG_ADDR);

    // ==========================================================
    // Per-pin level qualification
    genvar gi;
    generate
        for (gi = 0; gi < GPIO_N; gi++) begin : g_pin
            gils_level_filter #(
                .HOLD_CYCLES(IRQ_HOLD_CYCLES)
            ) u_filter (
                .clk_in(REF_CLK_IN),
                .rst_n_in(RESETN_IN),
                .pin_in(GPIO_PIN_IN[gi]),
                .active_high_in(GPIO_IRQ_ACTIVE_HIGH_IN[gi]),
                .active_out(pin_active[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Interrupt status: sticky, write one to clear, set wins
    assign w1c_mask = wr_irq ?
        WDATA_IN[IRQ_STATUS_LSB +: GPIO_N] : IRQ_STATUS_RESET;

    always_comb begin
        irq_status_nxt = irq_status_r & ~w1c_mask;
        // Set does not look at the enable bits
        irq_status_nxt = irq_status_nxt | pin_active;
    end

    always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            irq_status_r <= IRQ_STATUS_RESET;
        end else begin
            irq_status_r <= irq_status_nxt;
        end
    end

    // ==========================================================
    // Interrupt enables
    always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            irq_enable_r <= IRQ_ENABLE_RESET;
        end else if (wr_irq) begin
            irq_enable_r <= WDATA_IN[IRQ_ENABLE_LSB +: GPIO_N];
        end
    end

    // ==========================================================
    // Combined interrupt towards the chip level
    // Registered so the pin never glitches on decode changes
    always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            chip_status_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            chip_status_r <= |(irq_status_r & irq_enable_r);
            irq_r <= (|(irq_status_r & irq_enable_r))
                && CHIP_IRQ_GPIO_ENABLE_IN;
        end
    end

    assign CHIP_IRQ_STATUS_GPIO_OUT = chip_status_r;
    assign IRQ_OUT = irq_r;

    // ==========================================================
    // Indicator configuration with strap defaults
    gils_indicator_cfg u_led_pin_config (
        .clk_in(REF_CLK_IN),
        .rst_n_in(RESETN_IN),
        .select_strap_in(INDICATOR_SELECT_STRAP_IN),
        .function_strap_in(INDICATOR_FUNCTION_STRAP_IN),
        .rom_load_in(ROM_LOAD_VALID_IN),
        .rom_select_in(ROM_LOAD_SELECT_IN),
        .rom_function_in(ROM_LOAD_FUNCTION_IN),
        .host_wr_in(wr_led),
        .host_select_in(WDATA_IN[PIN_SELECT_LSB +: LED_N]),
        .host_function_in(WDATA_IN[FUNCTION_LSB +: FUNC_W]),
        .select_out(pin_select),
        .function_out(pin_function)
    );

    assign INDICATOR_PIN_SELECT_OUT = pin_select;
    assign INDICATOR_FUNCTION_SELECT_OUT = pin_function;

    // ==========================================================
    // Per-pin function, zero on pins left as GPIO
    always_comb begin
        pin_func_nxt = '0;
        for (int i = 0; i < LED_N; i++) begin
            if (pin_select[i]) begin
                pin_func_nxt[2*i +: 2] = pin_function;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            pin_func_r <= '0;
        end else begin
            pin_func_r <= pin_func_nxt;
        end
    end

    assign INDICATOR_PIN_FUNCTION_OUT = pin_func_r;

    // ==========================================================
    // Pin drive: LED pins are always outputs
    always_comb begin
        pin_out_nxt = GPIO_DATA_IN;
        pin_oe_nxt = GPIO_DIR_IN;
        for (int i = 0; i < LED_N; i++) begin
            if (pin_select[i]) begin
                pin_out_nxt[i] =
                    INDICATOR_SOURCE_IN[4*i + int'(pin_function)];
                pin_oe_nxt[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            pin_out_r <= '0;
            pin_oe_r <= '0;
        end else begin
            pin_out_r <= pin_out_nxt;
            pin_oe_r <= pin_oe_nxt;
        end
    end

    assign GPIO_PIN_OUT = pin_out_r;
    assign GPIO_PIN_OE_OUT = pin_oe_r;

    // ==========================================================
    // Read path: data stand the cycle after the strobe only
    always_comb begin
        rdata_nxt = READ_ZERO;
        if (rd_irq) begin
            rdata_nxt[IRQ_STATUS_LSB +: GPIO_N] = irq_status_r;
            rdata_nxt[IRQ_ENABLE_LSB +: GPIO_N] = irq_enable_r;
        end else if (rd_led) begin
            rdata_nxt[PIN_SELECT_LSB +: LED_N] = pin_select;
            rdata_nxt[FUNCTION_LSB +: FUNC_W] = pin_function;
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            rdata_r <= READ_ZERO;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign RDATA_OUT = rdata_r;

endmodule // gils_top

`default_nettype wire

// *** verif/gils_checker.sv ***
`timescale 1ns/1ps
`default_nettype none

module gils_checker
    import gils_pkg::*;
(
    input wire logic REF_CLK_IN,
    input wire logic RESETN_IN,
    input wire logic [gils_pkg::ADDR_W-1:0] ADDR_IN,
    input wire logic [gils_pkg::DATA_W-1:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic [gils_pkg::DATA_W-1:0] RDATA_OUT,
    input wire logic [gils_pkg::GPIO_N-1:0] GPIO_PIN_IN,
    input wire logic [gils_pkg::GPIO_N-1:0] GPIO_IRQ_ACTIVE_HIGH_IN,
    input wire logic [gils_pkg::GPIO_N-1:0] GPIO_DATA_IN,
    input wire logic [gils_pkg::GPIO_N-1:0] GPIO_DIR_IN,
    input wire logic [4*gils_pkg::LED_N-1:0] INDICATOR_SOURCE_IN,
    input wire logic [gils_pkg::GPIO_N-1:0] GPIO_PIN_OUT,
    input wire logic [gils_pkg::GPIO_N-1:0] GPIO_PIN_OE_OUT,
    input wire logic CHIP_IRQ_GPIO_ENABLE_IN,
    input wire logic CHIP_IRQ_STATUS_GPIO_OUT,
    input wire logic IRQ_OUT,
    input wire logic [gils_pkg::LED_N-1:0] INDICATOR_PIN_SELECT_OUT,
    input wire logic [gils_pkg::FUNC_W-1:0] INDICATOR_FUNCTION_SELECT_OUT,
    input wire logic [2*gils_pkg::LED_N-1:0] INDICATOR_PIN_FUNCTION_OUT
);
    logic [2*LED_N-1:0] exp_pf;
    logic [GPIO_N-1:0] exp_oe;
    logic [GPIO_N-1:0] exp_out;
    logic [3:0] held_cnt_r;

    // ==========
    // Pin mux model, compared one cycle later
    always_comb begin
        exp_pf = '0;
        exp_oe = GPIO_DIR_IN;
        exp_out = GPIO_DATA_IN;
        for (int i = 0; i < LED_N; i++) begin
            if (INDICATOR_PIN_SELECT_OUT[i]) begin
                exp_pf[2*i+:2] = INDICATOR_FUNCTION_SELECT_OUT;
                exp_oe[i] = 1'b1;
                exp_out[i] =
                    INDICATOR_SOURCE_IN[4*i+INDICATOR_FUNCTION_SELECT_OUT];
            end
        end
    end

    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!RESETN_IN);

    // Earlier consecutive samples of pin 0 at its active level.
    // A counter keeps the long hold out of the property's repetition.
    always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            held_cnt_r <= 4'h0;
        end else if (GPIO_PIN_IN[0] != GPIO_IRQ_ACTIVE_HIGH_IN[0]) begin
            held_cnt_r <= 4'h0;
        end else if (held_cnt_r != 4'hf) begin
            held_cnt_r <= held_cnt_r + 4'h1;
        end
    end

    sequence pin0_held;
        GPIO_PIN_IN[0] == GPIO_IRQ_ACTIVE_HIGH_IN[0];
    endsequence
    sequence status_read;
        RD_IN && ADDR_IN == GPIO_IRQ_STATUS_ENABLE_ADDR;
    endsequence

    // ==========
    // Register bus
    rdata_idle_a: assert property (
        !$past(RD_IN) |-> RDATA_OUT == READ_ZERO)
        else $error("read data not zero outside read cycle");
    unmapped_zero_a: assert property (
        RD_IN && ADDR_IN != GPIO_IRQ_STATUS_ENABLE_ADDR
        && ADDR_IN != LED_PIN_CONFIG_ADDR |=> RDATA_OUT == READ_ZERO)
        else $error("unmapped read not zero");
    status_rsvd_a: assert property (
        status_read |=> RDATA_OUT[31:28] == 4'h0 && RDATA_OUT[15:12] == 4'h0)
        else $error("reserved irq bits not zero");
    led_rsvd_a: assert property (
        RD_IN && ADDR_IN == LED_PIN_CONFIG_ADDR |=> RDATA_OUT[31:10] == '0)
        else $error("reserved indicator bits not zero");

    // ==========
    // Interrupt path
    irq_capture_a: assert property (
        (pin0_held and status_read) ##0 (held_cnt_r >= 4'h9)
        |=> RDATA_OUT[0])
        else $error("held level on pin 0 not captured");
    chip_or_a: assert property (
        status_read |=> CHIP_IRQ_STATUS_GPIO_OUT
        == |(RDATA_OUT[11:0] & RDATA_OUT[27:16]))
        else $error("chip status differs from enabled status");
    irq_gate_a: assert property (
        $past(RESETN_IN) |-> IRQ_OUT
        == (CHIP_IRQ_STATUS_GPIO_OUT && $past(CHIP_IRQ_GPIO_ENABLE_IN)))
        else $error("interrupt pin not gated by chip enable");
    enable_clear_a: assert property (
        WR_IN && ADDR_IN == GPIO_IRQ_STATUS_ENABLE_ADDR
        && WDATA_IN[27:16] == 12'h000 |-> ##2 !CHIP_IRQ_STATUS_GPIO_OUT)
        else $error("chip status with all enables off");

    // ==========
    // Indicator pins
    pin_func_a: assert property (
        $past(RESETN_IN) |-> INDICATOR_PIN_FUNCTION_OUT == $past(exp_pf))
        else $error("per pin function wrong");
    pin_mux_a: assert property (
        $past(RESETN_IN) |-> GPIO_PIN_OE_OUT == $past(exp_oe)
        && (GPIO_PIN_OUT & GPIO_PIN_OE_OUT) == $past(exp_out & exp_oe))
        else $error("pin drive or enable wrong");
endmodule // gils_checker

bind gils_top gils_checker u_gils_checker (
    .REF_CLK_IN(REF_CLK_IN), .RESETN_IN(RESETN_IN), .ADDR_IN(ADDR_IN),
    .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
    .RDATA_OUT(RDATA_OUT), .GPIO_PIN_IN(GPIO_PIN_IN),
    .GPIO_IRQ_ACTIVE_HIGH_IN(GPIO_IRQ_ACTIVE_HIGH_IN),
    .GPIO_DATA_IN(GPIO_DATA_IN), .GPIO_DIR_IN(GPIO_DIR_IN),
    .INDICATOR_SOURCE_IN(INDICATOR_SOURCE_IN), .GPIO_PIN_OUT(GPIO_PIN_OUT),
    .GPIO_PIN_OE_OUT(GPIO_PIN_OE_OUT),
    .CHIP_IRQ_GPIO_ENABLE_IN(CHIP_IRQ_GPIO_ENABLE_IN),
    .CHIP_IRQ_STATUS_GPIO_OUT(CHIP_IRQ_STATUS_GPIO_OUT), .IRQ_OUT(IRQ_OUT),
    .INDICATOR_PIN_SELECT_OUT(INDICATOR_PIN_SELECT_OUT),
    .INDICATOR_FUNCTION_SELECT_OUT(INDICATOR_FUNCTION_SELECT_OUT),
    .INDICATOR_PIN_FUNCTION_OUT(INDICATOR_PIN_FUNCTION_OUT));

`default_nettype wire

// *** verif/gils_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module gils_pin_model
    import gils_pkg::*;
(
    input wire logic clk_in,
    input wire logic [gils_pkg::GPIO_N-1:0] act_high_in,
    input wire logic [gils_pkg::GPIO_N-1:0] fire_in,
    input wire logic [gils_pkg::GPIO_N-1:0] oe_in,
    input wire logic [gils_pkg::GPIO_N-1:0] out_in,
    output logic [gils_pkg::GPIO_N-1:0] pin_out
);
    logic [GPIO_N-1:0] hold_r = '0;
    int cnt_r = 0;

    // ==========
    // External source: an event stays active past the minimum level time
    always_ff @(posedge clk_in) begin
        if (fire_in != '0) begin
            hold_r <= fire_in;
            cnt_r <= IRQ_HOLD_CYCLES + 1;
        end else if (cnt_r > 0) begin
            cnt_r <= cnt_r - 1;
        end else begin
            hold_r <= '0;
        end
    end

    // Pins the device drives follow it; the rest idle at the inactive level
    assign pin_out = (oe_in & out_in) | (~oe_in & (act_high_in ~^ hold_r));
endmodule // gils_pin_model

`default_nettype wire

// *** verif/tb_gils_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_gils_top;
    import gils_pkg::*;
    localparam logic [ADDR_W-1:0] led_ad = LED_PIN_CONFIG_ADDR;
    localparam logic [ADDR_W-1:0] irq_ad = GPIO_IRQ_STATUS_ENABLE_ADDR;
    logic clk = 1'b0;
    logic rst_n, wr, rd, chip_en, rom_v, chip_st, irq;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, src;
    logic [GPIO_N-1:0] pin, pol, gdata, gdir, fire, pout, poe;
    logic [LED_N-1:0] s_strap, rom_s, sel_o;
    logic [FUNC_W-1:0] f_strap, rom_f, fun_o;
    logic [2*LED_N-1:0] pfun;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;

    always #2.5 clk = ~clk;

    gils_top u_gils_top (.REF_CLK_IN(clk), .RESETN_IN(rst_n), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
        .GPIO_PIN_IN(pin), .GPIO_IRQ_ACTIVE_HIGH_IN(pol),
        .GPIO_DATA_IN(gdata), .GPIO_DIR_IN(gdir), .INDICATOR_SOURCE_IN(src),
        .GPIO_PIN_OUT(pout), .GPIO_PIN_OE_OUT(poe),
        .CHIP_IRQ_GPIO_ENABLE_IN(chip_en), .CHIP_IRQ_STATUS_GPIO_OUT(chip_st),
        .IRQ_OUT(irq), .INDICATOR_SELECT_STRAP_IN(s_strap),
        .INDICATOR_FUNCTION_STRAP_IN(f_strap), .ROM_LOAD_VALID_IN(rom_v),
        .ROM_LOAD_SELECT_IN(rom_s), .ROM_LOAD_FUNCTION_IN(rom_f),
        .INDICATOR_PIN_SELECT_OUT(sel_o),
        .INDICATOR_FUNCTION_SELECT_OUT(fun_o),
        .INDICATOR_PIN_FUNCTION_OUT(pfun));

    gils_pin_model u_gils_pin_model (.clk_in(clk), .act_high_in(pol),
        .fire_in(fire), .oe_in(poe), .out_in(pout), .pin_out(pin));

    // ==========
    // Helpers
    task automatic check(input string name, input logic [31:0] seen,
            input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    function automatic logic [15:0] pf_exp(input logic [7:0] s,
            input logic [1:0] f);
        for (int i = 0; i < 8; i++)
            pf_exp[2*i+:2] = s[i] ? f : 2'h0;
    endfunction

    // Only driven pins are compared; undriven output values are don't-care
    function automatic logic [23:0] drv_exp(input logic [7:0] s,
            input logic [1:0] f);
        logic [11:0] oe;
        logic [11:0] o;
        oe = gdir | {4'h0, s};
        o = gdata;
        for (int i = 0; i < 8; i++)
            if (s[i]) o[i] = src[4*i+f];
        return {oe, o & oe};
    endfunction

    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            tally_and_finish();
        end
    end

    // ==========
    // Main sequence
    initial begin
        logic [31:0] r;
        logic [31:0] d;
        logic [11:0] en;
        void'($urandom(10));
        {rst_n, wr, rd, chip_en, rom_v, fire} = '0;
        {addr, wdata, rom_s, rom_f, pol, gdata, gdir, src} = '0;
        s_strap = 8'($urandom);
        f_strap = 2'($urandom);
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        bus_rd(led_ad, d);
        check("strap fields", d, {22'h0, f_strap, s_strap});
        bus_rd(irq_ad, d);
        check("enable reset", d & 32'h0FFF_0000, 32'h0);
        $display("test reset done");
        for (int f = 0; f < 4; f++) begin
            r = $urandom;
            r[9:8] = f[1:0];
            gdir <= 12'($urandom);
            gdata <= 12'($urandom);
            src <= $urandom;
            bus_wr(led_ad, r);
            repeat (3) @(posedge clk);
            #1;
            check("pin select", 32'(sel_o), 32'(r[7:0]));
            check("function", 32'(fun_o), 32'(r[9:8]));
            check("pin function", 32'(pfun), 32'(pf_exp(r[7:0], f[1:0])));
            check("pin drive", 32'({poe, pout & poe}), 32'(drv_exp(r[7:0], f[1:0])));
            bus_rd(led_ad, d);
            check("indicator reg", d, r & 32'h0000_03FF);
        end
        $display("test indicator done");
        @(posedge clk);
        rom_s <= 8'($urandom);
        rom_f <= 2'($urandom);
        rom_v <= 1'b1;
        addr <= led_ad;
        wdata <= 32'h0000_0000;
        wr <= 1'b1;
        @(posedge clk);
        {rom_v, wr} <= 2'b00;
        bus_rd(led_ad, d);
        check("loader wins", d, {22'h0, rom_f, rom_s});
        bus_wr(12'h1c0, 32'hFFFF_FFFF);
        bus_rd(12'h1c0, d);
        check("unmapped", d, 32'h0);
        $display("test loader done");
        pol <= 12'($urandom);
        gdir <= '0;
        bus_wr(led_ad, 32'h0);
        repeat (12) @(posedge clk);
        bus_wr(irq_ad, 32'h0000_0FFF);
        fire <= 12'h001;
        repeat (14) @(posedge clk);
        bus_wr(irq_ad, 32'h0000_0001);
        bus_rd(irq_ad, d);
        check("set beats clear", d, 32'h0000_0001);
        fire <= '0;
        repeat (20) @(posedge clk);
        for (int k = 0; k < 12; k++) begin
            en = 12'($urandom);
            chip_en <= 1'($urandom);
            bus_wr(irq_ad, {4'h0, en, 16'h0FFF});
            fire <= 12'h001 << k;
            @(posedge clk);
            fire <= '0;
            repeat (20) @(posedge clk);
            bus_rd(irq_ad, d);
            check("status", d, {4'h0, en, 4'h0, 12'h001 << k});
            check("chip status", 32'(chip_st), 32'(en[k]));
            check("irq pin", 32'(irq), 32'(en[k] & chip_en));
            bus_wr(irq_ad, {4'h0, en, 16'h0000});
            bus_rd(irq_ad, d);
            check("zero keeps", d, {4'h0, en, 4'h0, 12'h001 << k});
            bus_wr(irq_ad, {4'hF, en, 4'hF, 12'h001 << k});
            bus_rd(irq_ad, d);
            check("one clears", d, {4'h0, en, 16'h0000});
            check("chip cleared", 32'(chip_st), 32'h0);
        end
        bus_wr(irq_ad, 32'h0000_0FFF);
        $display("test interrupt done");
        tally_and_finish();
    end
endmodule // tb_gils_top

`default_nettype wire
